// ===== fbp_defines.svh
// constants of the flash block-protect logic: reset values, field codes, timing
// assumes inclusion by the package and the design modules only
`ifndef FBP_DEFINES_SVH
`define FBP_DEFINES_SVH

// ---------------------------------------------------------------
// array geometry
// ---------------------------------------------------------------
`define FBP_ADDR_W         25
`define FBP_ADDR_MAX       25'h1FFFFFF
`define FBP_BLOCK_SHIFT    5'h10
`define FBP_BP_NONE        4'h0
`define FBP_BP_MAX         4'h9
`define FBP_ERASED_BYTE    8'hFF

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define FBP_STATUS_RST     11'h000

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define FBP_CLK_PERIOD_NS  25.0
`define FBP_SUPPLY_SEL_MS  2.5

`endif

// ===== fbp_host_model.sv
// host and array-engine model facing the block-protect controller
// assumes sys_clk from the bench; commands are sent through the send task
`timescale 1ns/1ps
module fbp_host_model
  import fbp_pkg::*;
#(
  parameter int unsigned OP_CYC = 3
)(
  // clock
  input  wire logic     sys_clk,
  // answers from the controller
  input  wire logic     exec_valid,
  input  wire fbp_cmd_t exec_cmd,
  // command hand-over and engine
  output logic          cmd_valid,
  output fbp_cmd_t      cmd,
  output logic          op_done
);
  int unsigned cnt;

  initial begin
    cmd_valid = 1'b0;
    cmd       = '0;
    op_done   = 1'b0;
    cnt       = 0;
  end

  // engine finishes each accepted change after OP_CYC cycles
  always @(negedge sys_clk) begin
    op_done <= (cnt == 1);
    if (exec_valid && exec_cmd.kind inside {FBP_CMD_WRSR, FBP_CMD_PROGRAM, FBP_CMD_ERASE, FBP_CMD_CHIP_ERASE})
      cnt <= OP_CYC;
    else if (cnt != 0)
      cnt <= cnt - 1;
  end

  // one command per select window, released to a non-stale value
  task automatic send(input fbp_cmd_t c);
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd       = c;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    cmd       = ~c;
  endtask : send
endmodule : fbp_host_model

// ===== fbp_pkg.sv
// types shared by the flash block-protect logic
// assumes fbp_defines.svh is on the include path
package fbp_pkg;
  `include "fbp_defines.svh"

  typedef logic [`FBP_ADDR_W-1:0] fbp_addr_t;

  // command classes delivered by the serial front end
  typedef enum logic [3:0] {
    FBP_CMD_NONE, FBP_CMD_READ, FBP_CMD_WRITE_ENABLE_COMMAND, FBP_CMD_WRDI, FBP_CMD_WRSR,
    FBP_CMD_PROGRAM, FBP_CMD_ERASE, FBP_CMD_CHIP_ERASE, FBP_CMD_DPD_ENTER,
    FBP_CMD_DPD_RELEASE
  } fbp_cmd_kind_t;

  // writable protection configuration
  typedef struct packed {
    logic [1:0] status_protect_bits;
    logic       complement_bit;
    logic       protect_scheme_select;
    logic [4:0] block_protect_field;
  } fbp_prot_cfg_t;

  // status word: configuration plus busy and latch
  typedef struct packed {
    fbp_prot_cfg_t cfg;
    logic          busy;
    logic          write_enable_latch;
  } fbp_status_t;

  // one command, handed over at chip-select release
  typedef struct packed {
    fbp_cmd_kind_t kind;
    logic          complete;
    logic          byte_aligned;
    fbp_addr_t     addr_lo;
    fbp_addr_t     addr_hi;
    fbp_prot_cfg_t sr_wdata;
  } fbp_cmd_t;

  typedef enum logic [2:0] {
    FBP_REJ_NONE, FBP_REJ_POWERUP, FBP_REJ_DPD, FBP_REJ_BUSY,
    FBP_REJ_FORM, FBP_REJ_WEL, FBP_REJ_PROTECT
  } fbp_reject_t;

  typedef enum logic [1:0] {FBP_ST_STANDBY, FBP_ST_BUSY, FBP_ST_DPD} fbp_state_t;
endpackage : fbp_pkg

// ===== fbp_protect.sv
// write-protection controller of a serial flash: status word, latch, range checks
// assumes a serial front end on sys_clk that hands over each command at chip-select release
//
// What this block and its host do
// RQ1 - The host keeps select off until 2.5 ms after supply is good; commands before that are refused. The host model's send task does not wait for select_ready.
// RQ2 - As delivered the array reads FFh and the status word reads all zero.
// RQ3 - After power-up the controller sits in standby with nothing in progress.
// RQ4 - Contents change only after a complete, well formed command has finished.
// RQ5 - A modifying command not ending on a byte boundary is rejected.
// RQ6 - Data-changing commands need the write-enable latch, set by the write-enable command.
// RQ7 - With the protect pin low, block-protect and status-protect bits cannot be written.
// RQ8 - In deep power-down every command but the release is ignored.
// RQ9 - The block-protect bits mark a readable region that cannot be programmed or erased.
// RQ10 - Without complement, bit4 picks top or bottom and codes 1..9 protect 1..256 blocks of 64KB.
// RQ11 - With complement, the exact complement region is protected.
// RQ12 - After power loss during erase the host should erase the region again.
// RQ13 - A program or erase touching any protected byte is ignored entirely.
// RQ14 - With the scheme select set, individual locks govern instead of the block decode.
// RQ15 - The full target range is checked against the current decode when a command is taken.
`timescale 1ns/1ps
`include "fbp_defines.svh"
module fbp_protect
  import fbp_pkg::*;
#(
  parameter int unsigned SEL_DELAY_CYC =
    int'($ceil(`FBP_SUPPLY_SEL_MS * 1.0e6 / `FBP_CLK_PERIOD_NS))
)(
  // clock and power-on reset
  input  wire logic  sys_clk,
  input  wire logic  rst_n,
  // pins
  input  wire logic  wp_n_pin,
  // command hand-over from the serial front end
  input  wire logic  cmd_valid,
  input  wire fbp_cmd_t cmd,
  // array engine and individual lock lookup
  input  wire logic  op_done,
  input  wire logic  indiv_lock_hit,
  // status and results
  output fbp_status_t status,
  output logic        exec_valid,
  output fbp_cmd_t    exec_cmd,
  output logic        reject_valid,
  output fbp_reject_t reject_reason,
  output logic        select_ready,
  output logic        deep_pd,
  output logic [7:0]  erase_fill_byte
);
  localparam int unsigned CW = $clog2(SEL_DELAY_CYC + 1);

  logic        wp_meta_q, wp_sync_q;
  logic [CW-1:0] pu_cnt_q;
  logic        ready_q;
  fbp_state_t  state_q, state_d;
  fbp_status_t status_q, status_d;
  logic        exec_q, rej_q;
  fbp_cmd_t    exec_cmd_q;
  fbp_reject_t rej_reason_q;
  logic        prot_valid;
  fbp_addr_t   prot_lo, prot_hi;

  // ---------------------------------------------------------------
  // protect pin synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_meta_q <= 1'b1;
      wp_sync_q <= 1'b1;
    end else begin
      wp_meta_q <= wp_n_pin;
      wp_sync_q <= wp_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // power-up select guard
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pu_cnt_q <= '0;
      ready_q  <= 1'b0;
    end else if (!ready_q) begin
      pu_cnt_q <= pu_cnt_q + CW'(1);
      ready_q  <= (pu_cnt_q == CW'(SEL_DELAY_CYC - 1)); // [RQ1]
    end
  end

  // ---------------------------------------------------------------
  // range decode from current status bits
  // ---------------------------------------------------------------
  fbp_range_decode u_decode (
    .cfg        (status_q.cfg),
    .prot_valid (prot_valid),
    .prot_lo    (prot_lo),
    .prot_hi    (prot_hi)
  );

  // ---------------------------------------------------------------
  // command classes
  // ---------------------------------------------------------------
  wire logic is_chip   = (cmd.kind == FBP_CMD_CHIP_ERASE);
  wire logic is_ranged = (cmd.kind == FBP_CMD_PROGRAM) || (cmd.kind == FBP_CMD_ERASE) || is_chip;
  wire logic is_change = is_ranged || (cmd.kind == FBP_CMD_WRSR);
  wire logic is_modify = is_change || (cmd.kind inside {FBP_CMD_WRITE_ENABLE_COMMAND, FBP_CMD_WRDI,
                                                        FBP_CMD_DPD_ENTER, FBP_CMD_DPD_RELEASE});
  wire fbp_addr_t tgt_lo = is_chip ? '0 : cmd.addr_lo;
  wire fbp_addr_t tgt_hi = is_chip ? `FBP_ADDR_MAX : cmd.addr_hi;

  // whole target range against decoded bounds or individual locks [RQ15] [RQ14]
  wire logic range_hit = status_q.cfg.protect_scheme_select ? indiv_lock_hit
                         : (prot_valid && (tgt_lo <= prot_hi) && (tgt_hi >= prot_lo));
  wire logic form_ok   = cmd.complete && (!is_modify || cmd.byte_aligned) // [RQ4] [RQ5]
                         && (!is_ranged || (tgt_lo <= tgt_hi));

  // refusal reason, highest priority first
  wire fbp_reject_t reason =
      !ready_q                                                        ? FBP_REJ_POWERUP : // [RQ1]
      (state_q == FBP_ST_DPD && cmd.kind != FBP_CMD_DPD_RELEASE)      ? FBP_REJ_DPD     : // [RQ8]
      (state_q == FBP_ST_BUSY)                                        ? FBP_REJ_BUSY    :
      (state_q != FBP_ST_DPD && cmd.kind == FBP_CMD_DPD_RELEASE)      ? FBP_REJ_FORM    :
      !form_ok                                                        ? FBP_REJ_FORM    : // [RQ5]
      (is_change && !status_q.write_enable_latch)                     ? FBP_REJ_WEL     : // [RQ6]
      (is_ranged && range_hit)                                        ? FBP_REJ_PROTECT : // [RQ13]
                                                                        FBP_REJ_NONE;
  wire logic take   = cmd_valid && (cmd.kind != FBP_CMD_NONE);
  wire logic accept = take && (reason == FBP_REJ_NONE);
  wire logic acc_sr = accept && (cmd.kind == FBP_CMD_WRSR);

  // ---------------------------------------------------------------
  // state and status next values
  // ---------------------------------------------------------------
  always_comb begin
    state_d  = state_q;
    status_d = status_q;
    unique case (state_q)
      FBP_ST_STANDBY: begin
        if (accept && is_change)                     state_d = FBP_ST_BUSY;
        else if (accept && cmd.kind == FBP_CMD_DPD_ENTER) state_d = FBP_ST_DPD;
      end
      FBP_ST_BUSY:    if (op_done) state_d = FBP_ST_STANDBY;
      FBP_ST_DPD:     if (accept) state_d = FBP_ST_STANDBY; // [RQ8]
    endcase
    if (accept && cmd.kind == FBP_CMD_WRITE_ENABLE_COMMAND) status_d.write_enable_latch = 1'b1; // [RQ6]
    if (accept && (cmd.kind == FBP_CMD_WRDI || is_change)) status_d.write_enable_latch = 1'b0;
    if (acc_sr) begin
      status_d.cfg.complement_bit        = cmd.sr_wdata.complement_bit;
      status_d.cfg.protect_scheme_select = cmd.sr_wdata.protect_scheme_select;
      if (wp_sync_q) begin // [RQ7]
        status_d.cfg.block_protect_field = cmd.sr_wdata.block_protect_field;
        status_d.cfg.status_protect_bits = cmd.sr_wdata.status_protect_bits;
      end
    end
    status_d.busy = (state_d == FBP_ST_BUSY);
  end

  // state registers, standby and zero status after power-up [RQ3] [RQ2]
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= FBP_ST_STANDBY;
      status_q <= `FBP_STATUS_RST;
    end else begin
      state_q  <= state_d;
      status_q <= status_d;
    end
  end

  // result registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      exec_q       <= 1'b0;
      exec_cmd_q   <= '0;
      rej_q        <= 1'b0;
      rej_reason_q <= FBP_REJ_NONE;
    end else begin
      exec_q       <= accept;
      rej_q        <= take && !accept;
      if (take) begin
        exec_cmd_q   <= cmd;
        rej_reason_q <= reason;
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign status          = status_q;
  assign exec_valid      = exec_q;
  assign exec_cmd        = exec_cmd_q;
  assign reject_valid    = rej_q;
  assign reject_reason   = rej_reason_q;
  assign select_ready    = ready_q;
  assign deep_pd         = (state_q == FBP_ST_DPD);
  assign erase_fill_byte = `FBP_ERASED_BYTE; // [RQ2]

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  logic first_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) first_q <= 1'b1;
    else        first_q <= 1'b0;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_change_taken;
    take && is_change && ready_q && state_q == FBP_ST_STANDBY && form_ok;
  endsequence
  sequence s_latch_clear;
    !status_q.write_enable_latch;
  endsequence

  init_state_a:    assert property (first_q |-> state_q == FBP_ST_STANDBY && !exec_q
                                    && status_q == `FBP_STATUS_RST) // [RQ3]
    else $error("not in standby with zero status after reset");
  latch_gate_a:    assert property (s_latch_clear ##0 s_change_taken |=> !exec_q && rej_q
                                    && rej_reason_q == FBP_REJ_WEL) // [RQ6]
    else $error("change executed with latch clear");
  wp_lock_a:       assert property (acc_sr && !wp_sync_q |=> status_q.cfg.block_protect_field
                                    == $past(status_q.cfg.block_protect_field)
                                    && status_q.cfg.status_protect_bits
                                    == $past(status_q.cfg.status_protect_bits)) // [RQ7]
    else $error("protect bits written with pin low");
  dpd_ignore_a:    assert property (state_q == FBP_ST_DPD && take && cmd.kind != FBP_CMD_DPD_RELEASE
                                    |=> !exec_q && state_q == FBP_ST_DPD) // [RQ8]
    else $error("command obeyed in deep power-down");
  byte_bound_a:    assert property (take && is_modify && !cmd.byte_aligned |=> !exec_q && !$rose(status_q.busy)) // [RQ5]
    else $error("unaligned command executed");
  range_block_a:   assert property (take && is_ranged && range_hit |=> !exec_q) // [RQ13]
    else $error("protected range was changed");
  powerup_hold_a:  assert property (take && !ready_q |=> rej_q && rej_reason_q == FBP_REJ_POWERUP) // [RQ1]
    else $error("command taken before select delay");
  busy_until_a:    assert property (s_change_taken ##0 accept |=> status_q.busy
                                    && !status_q.write_enable_latch) // [RQ4]
    else $error("accepted change did not start busy");
  top_one_blk_a:   assert property (!status_q.cfg.complement_bit && status_q.cfg.block_protect_field == 5'h01
                                    |-> prot_valid && prot_lo == 25'h1FF0000 && prot_hi == `FBP_ADDR_MAX) // [RQ10]
    else $error("top one-block decode wrong");
  cmp_all_a:       assert property (status_q.cfg.complement_bit && status_q.cfg.block_protect_field[3:0] == 4'h0
                                    |-> prot_valid && prot_lo == '0 && prot_hi == `FBP_ADDR_MAX) // [RQ11]
    else $error("complement of none is not all");
endmodule : fbp_protect

// ===== fbp_range_decode.sv
// decodes protection configuration into one protected address range
// assumes a combinational use inside the protect controller
`timescale 1ns/1ps
`include "fbp_defines.svh"
module fbp_range_decode
  import fbp_pkg::*;
(
  // configuration
  input  wire fbp_prot_cfg_t cfg,
  // decoded range
  output logic               prot_valid,
  output fbp_addr_t          prot_lo,
  output fbp_addr_t          prot_hi
);
  // bytes in region of a code 1..9, minus one
  function automatic fbp_addr_t region_m1(input logic [3:0] code);
    logic [4:0] sh;
    sh = {1'b0, code} + `FBP_BLOCK_SHIFT - 5'h01;
    return (fbp_addr_t'(1) << sh) - fbp_addr_t'(1);
  endfunction : region_m1

  // ---------------------------------------------------------------
  // code classes
  // ---------------------------------------------------------------
  wire logic [3:0] low       = cfg.block_protect_field[3:0];
  wire logic       bottom    = cfg.block_protect_field[4];
  wire logic       code_none = (low == `FBP_BP_NONE);
  wire logic       code_all  = (low > `FBP_BP_MAX);
  wire fbp_addr_t  sz_m1     = region_m1(low);
  wire logic       full      = cfg.complement_bit ? code_none : code_all;

  // plain region (top or bottom), then its complement [RQ10] [RQ11]
  wire fbp_addr_t  lo_plain  = bottom ? '0 : `FBP_ADDR_MAX - sz_m1;
  wire fbp_addr_t  hi_plain  = bottom ? sz_m1 : `FBP_ADDR_MAX;
  wire fbp_addr_t  lo_cmp    = bottom ? sz_m1 + fbp_addr_t'(1) : '0;
  wire fbp_addr_t  hi_cmp    = bottom ? `FBP_ADDR_MAX : `FBP_ADDR_MAX - sz_m1 - fbp_addr_t'(1);

  // range selection
  assign prot_valid = cfg.complement_bit ? !code_all : !code_none; // [RQ9]
  assign prot_lo    = full ? '0 : (cfg.complement_bit ? lo_cmp : lo_plain);
  assign prot_hi    = full ? `FBP_ADDR_MAX : (cfg.complement_bit ? hi_cmp : hi_plain);
endmodule : fbp_range_decode

// ===== testbench.sv
// self-checking bench of the block-protect controller
// assumes fbp_pkg compiled first; select delay shortened to 8 cycles
`timescale 1ns/1ps
module testbench;
  import fbp_pkg::*;
  localparam int unsigned SEL_CYC = 8;
  logic sys_clk, rst_n, wp_n_pin, cmd_valid, op_done, indiv_lock_hit;
  fbp_cmd_t    cmd, exec_cmd;
  fbp_status_t status;
  fbp_reject_t reject_reason;
  logic        exec_valid, reject_valid, select_ready, deep_pd;
  logic [7:0]  erase_fill_byte;
  fbp_prot_cfg_t cur;
  int fails, n_checks, cyc;

  fbp_protect #(.SEL_DELAY_CYC(SEL_CYC)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .wp_n_pin(wp_n_pin),
    .cmd_valid(cmd_valid), .cmd(cmd), .op_done(op_done), .indiv_lock_hit(indiv_lock_hit), .status(status),
    .exec_valid(exec_valid), .exec_cmd(exec_cmd), .reject_valid(reject_valid), .reject_reason(reject_reason),
    .select_ready(select_ready), .deep_pd(deep_pd), .erase_fill_byte(erase_fill_byte));
  fbp_host_model host (.sys_clk(sys_clk), .exec_valid(exec_valid), .exec_cmd(exec_cmd), .cmd_valid(cmd_valid),
    .cmd(cmd), .op_done(op_done));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // send one command and judge the answer at the falling edge after the take, while the pulse stands
  task automatic issue(input fbp_cmd_kind_t k, input fbp_addr_t lo, input fbp_addr_t hi,
                       input logic al, input logic cp, input fbp_reject_t why);
    fbp_cmd_t c;
    c = '{kind: k, complete: cp, byte_aligned: al, addr_lo: lo, addr_hi: hi, sr_wdata: cur};
    host.send(c);
    check("exec_valid", exec_valid, why == FBP_REJ_NONE);
    check("reject_valid", reject_valid, why != FBP_REJ_NONE);
    if (why != FBP_REJ_NONE) check("reject_reason", reject_reason, why);
  endtask : issue

  task automatic wait_idle();
    for (int i = 0; i < 50 && status.busy !== 1'b0; i++) @(negedge sys_clk);
    check("busy", status.busy, 1'b0);
  endtask : wait_idle

  // write enable then status write of cur
  task automatic wrsr();
    issue(FBP_CMD_WRITE_ENABLE_COMMAND, '0, '0, 1'b1, 1'b1, FBP_REJ_NONE);
    issue(FBP_CMD_WRSR, '0, '0, 1'b1, 1'b1, FBP_REJ_NONE);
    wait_idle();
  endtask : wrsr

  // one configuration, one modifying command, expected outcome
  task automatic prot_case(input fbp_prot_cfg_t c, input fbp_cmd_kind_t k, input fbp_addr_t lo,
                           input fbp_addr_t hi, input logic bad);
    cur = c;
    wrsr();
    check("cfg", status.cfg, c);
    issue(FBP_CMD_WRITE_ENABLE_COMMAND, '0, '0, 1'b1, 1'b1, FBP_REJ_NONE);
    issue(k, lo, hi, 1'b1, 1'b1, bad ? FBP_REJ_PROTECT : FBP_REJ_NONE);
    wait_idle();
  endtask : prot_case

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    check("status", status, 11'h000);
    check("erase_fill", erase_fill_byte, 8'hFF);
    check("deep_pd", deep_pd, 1'b0);
    issue(FBP_CMD_WRITE_ENABLE_COMMAND, '0, '0, 1'b1, 1'b1, FBP_REJ_POWERUP);
    for (int i = 0; i < 3 * SEL_CYC && select_ready !== 1'b1; i++) @(negedge sys_clk);
    check("select_ready", select_ready, 1'b1);
    check("busy", status.busy, 1'b0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_form_wel();
    issue(FBP_CMD_WRITE_ENABLE_COMMAND, '0, '0, 1'b0, 1'b1, FBP_REJ_FORM);
    check("wel", status.write_enable_latch, 1'b0);
    issue(FBP_CMD_PROGRAM, 25'h10, 25'h1F, 1'b1, 1'b1, FBP_REJ_WEL);
    issue(FBP_CMD_WRITE_ENABLE_COMMAND, '0, '0, 1'b1, 1'b1, FBP_REJ_NONE);
    check("wel", status.write_enable_latch, 1'b1);
    issue(FBP_CMD_PROGRAM, 25'h10, 25'h1F, 1'b1, 1'b0, FBP_REJ_FORM);
    issue(FBP_CMD_ERASE, 25'h1F, 25'h10, 1'b1, 1'b1, FBP_REJ_FORM);
    issue(FBP_CMD_PROGRAM, 25'h10, 25'h1F, 1'b0, 1'b1, FBP_REJ_FORM);
    issue(FBP_CMD_PROGRAM, 25'h10, 25'h1F, 1'b1, 1'b1, FBP_REJ_NONE);
    check("busy", status.busy, 1'b1);
    check("wel", status.write_enable_latch, 1'b0);
    issue(FBP_CMD_READ, 25'h0, 25'h0, 1'b1, 1'b1, FBP_REJ_BUSY);
    wait_idle();
    $display("test form and latch done");
  endtask : t_form_wel

  task automatic t_decode();
    prot_case('{2'h0, 1'b0, 1'b0, 5'h01}, FBP_CMD_PROGRAM, 25'h1FF0000, 25'h1FF00FF, 1'b1);
    prot_case('{2'h0, 1'b0, 1'b0, 5'h01}, FBP_CMD_PROGRAM, 25'h1FEFF00, 25'h1FEFFFF, 1'b0);
    prot_case('{2'h0, 1'b0, 1'b0, 5'h01}, FBP_CMD_ERASE, 25'h1FE0000, 25'h1FFFFFF, 1'b1);
    prot_case('{2'h0, 1'b0, 1'b0, 5'h11}, FBP_CMD_ERASE, 25'h000F000, 25'h000FFFF, 1'b1);
    prot_case('{2'h0, 1'b0, 1'b0, 5'h11}, FBP_CMD_ERASE, 25'h0010000, 25'h001FFFF, 1'b0);
    prot_case('{2'h0, 1'b0, 1'b0, 5'h09}, FBP_CMD_PROGRAM, 25'h0FFFF00, 25'h0FFFFFF, 1'b0);
    prot_case('{2'h0, 1'b0, 1'b0, 5'h09}, FBP_CMD_PROGRAM, 25'h1000000, 25'h10000FF, 1'b1);
    prot_case('{2'h0, 1'b0, 1'b0, 5'h19}, FBP_CMD_PROGRAM, 25'h0FFFF00, 25'h0FFFFFF, 1'b1);
    prot_case('{2'h0, 1'b0, 1'b0, 5'h0A}, FBP_CMD_PROGRAM, 25'h1000000, 25'h10000FF, 1'b1);
    prot_case('{2'h0, 1'b0, 1'b0, 5'h00}, FBP_CMD_CHIP_ERASE, 25'h0, 25'h0, 1'b0);
    prot_case('{2'h0, 1'b1, 1'b0, 5'h01}, FBP_CMD_PROGRAM, 25'h1FF0000, 25'h1FF00FF, 1'b0);
    prot_case('{2'h0, 1'b1, 1'b0, 5'h01}, FBP_CMD_PROGRAM, 25'h1FEFF00, 25'h1FEFFFF, 1'b1);
    prot_case('{2'h0, 1'b1, 1'b0, 5'h00}, FBP_CMD_PROGRAM, 25'h1FFFF00, 25'h1FFFFFF, 1'b1);
    prot_case('{2'h0, 1'b1, 1'b0, 5'h1C}, FBP_CMD_CHIP_ERASE, 25'h0, 25'h0, 1'b0);
    prot_case('{2'h0, 1'b0, 1'b1, 5'h0A}, FBP_CMD_PROGRAM, 25'h1000000, 25'h10000FF, 1'b0);
    indiv_lock_hit = 1'b1;
    prot_case('{2'h0, 1'b0, 1'b1, 5'h00}, FBP_CMD_PROGRAM, 25'h0, 25'hFF, 1'b1);
    indiv_lock_hit = 1'b0;
    $display("test decode done");
  endtask : t_decode

  task automatic t_wp_dpd();
    wp_n_pin = 1'b0;
    repeat (3) @(negedge sys_clk);
    cur = '{2'h3, 1'b1, 1'b0, 5'h1F};
    wrsr();
    check("bp_locked", {status.cfg.status_protect_bits, status.cfg.block_protect_field}, 7'h00);
    check("cmp_free", status.cfg.complement_bit, 1'b1);
    wp_n_pin = 1'b1;
    issue(FBP_CMD_DPD_RELEASE, '0, '0, 1'b1, 1'b1, FBP_REJ_FORM);
    issue(FBP_CMD_DPD_ENTER, '0, '0, 1'b1, 1'b1, FBP_REJ_NONE);
    check("deep_pd", deep_pd, 1'b1);
    issue(FBP_CMD_WRITE_ENABLE_COMMAND, '0, '0, 1'b1, 1'b1, FBP_REJ_DPD);
    issue(FBP_CMD_READ, '0, '0, 1'b1, 1'b1, FBP_REJ_DPD);
    issue(FBP_CMD_DPD_RELEASE, '0, '0, 1'b1, 1'b1, FBP_REJ_NONE);
    check("deep_pd", deep_pd, 1'b0);
    $display("test protect pin and power-down done");
  endtask : t_wp_dpd

  // latch clear by disable, supply lost mid-erase, host erases the region again
  task automatic t_power_loss();
    cur = '0;
    wrsr();
    issue(FBP_CMD_WRITE_ENABLE_COMMAND, '0, '0, 1'b1, 1'b1, FBP_REJ_NONE);
    issue(FBP_CMD_WRDI, '0, '0, 1'b1, 1'b1, FBP_REJ_NONE);
    check("wel", status.write_enable_latch, 1'b0);
    issue(FBP_CMD_WRITE_ENABLE_COMMAND, '0, '0, 1'b1, 1'b1, FBP_REJ_NONE);
    issue(FBP_CMD_ERASE, 25'h0020000, 25'h002FFFF, 1'b1, 1'b1, FBP_REJ_NONE);
    check("busy", status.busy, 1'b1);
    rst_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    check("status", status, 11'h000);
    check("select_ready", select_ready, 1'b0);
    for (int i = 0; i < 3 * SEL_CYC && select_ready !== 1'b1; i++) @(negedge sys_clk);
    issue(FBP_CMD_WRITE_ENABLE_COMMAND, '0, '0, 1'b1, 1'b1, FBP_REJ_NONE);
    issue(FBP_CMD_ERASE, 25'h0020000, 25'h002FFFF, 1'b1, 1'b1, FBP_REJ_NONE);
    check("exec_cmd", exec_cmd.kind, FBP_CMD_ERASE);
    wait_idle();
    $display("test power loss done");
  endtask : t_power_loss

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize

  // cut a hang short
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end

  initial begin
    rst_n = 1'b0;
    wp_n_pin = 1'b1;
    indiv_lock_hit = 1'b0;
    cur = '0;
    fails = 0;
    n_checks = 0;
    cyc = 0;
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    t_reset();
    t_form_wel();
    t_decode();
    t_wp_dpd();
    t_power_loss();
    summarize();
  end
endmodule : testbench
